// ===== msc_mode_latch.sv
// Mode pin latch for readback and reset-time strap capture
`timescale 1ns/1ps
`include "msc_regs.svh"
module msc_mode_latch
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] mode_pins_i,
    input  wire logic       rd_mode_i,
    output logic [2:0]      readback_o,
    output logic [2:0]      strap_o,
    output logic            strap_valid_o
);
    logic [2:0] next_readback;
    logic [2:0] next_strap;
    logic       next_strap_valid;

    always_comb
    begin
        next_readback    = readback_o;
        next_strap       = strap_o;
        next_strap_valid = 1'b1;
        if (rd_mode_i)
        begin
            next_readback = mode_pins_i;
        end
        if (!strap_valid_o)
        begin
            next_strap = mode_pins_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            readback_o    <= 3'h0;
            strap_o       <= 3'h0;
            strap_valid_o <= 1'b0;
        end
        else
        begin
            readback_o    <= next_readback;
            strap_o       <= next_strap;
            strap_valid_o <= next_strap_valid;
        end
    end
endmodule : msc_mode_latch

// ===== msc_pkg.sv
// Types for the mode and system control block
package msc_pkg;
    typedef enum logic [1:0]
    {
        MSC_MODE_EXP_NOROM_16,
        MSC_MODE_EXP_NOROM_8,
        MSC_MODE_EXP_ROM,
        MSC_MODE_SINGLE
    } msc_mode_t;

    typedef enum logic
    {
        MSC_APB_SETUP,
        MSC_APB_ACCESS
    } msc_apb_t;
endpackage : msc_pkg

// ===== msc_regs.svh
// Register offsets, field positions, reset values and constants
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

`define MSC_ADDR_SYSCTL      16'hFF39
`define MSC_ADDR_MODE        16'hFF3B
`define MSC_ADDR_FGATE       16'hFF42
`define MSC_SYSCTL_RESET     8'h01
`define MSC_FGATE_RESET      8'h00
`define MSC_MODE_FIXED       8'h80
`define MSC_SYSCTL_WMASK     8'h3D
`define MSC_FGATE_WMASK      8'h08
`define MSC_BIT_ONCHIP_RAM_ENABLE         0
`define MSC_BIT_LOW_STROBE_OUT_DISABLE        2
`define MSC_BIT_NONMASK_IRQ_EDGE_SEL        3
`define MSC_BIT_INTM_LO      4
`define MSC_BIT_INTM_HI      5
`define MSC_BIT_FLASH_REGS_SELECT        3
`define MSC_PINS_MODE4       3'h4
`define MSC_PINS_MODE5       3'h5
`define MSC_PINS_MODE6       3'h6
`define MSC_PINS_MODE7       3'h7
`define MSC_ADDR_LIMIT_BITS  24
`define MSC_FLASH_LO         24'hFF_FFC8
`define MSC_FLASH_HI         24'hFF_FFCB
`define MSC_UNDEF_VALUE      8'h00
`define MSC_ZERO8            8'h00
`define MSC_ZERO32           32'h0000_0000

`endif

// ===== msc_sva.sv
// Concurrent checks on the mode and system control block ports
`timescale 1ns/1ps
`include "msc_regs.svh"
module msc_sva
(
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic [2:0]  mode_pins_i,
    input wire logic        hw_standby_i,
    input wire logic [7:0]  area_is16_i,
    input wire logic [31:0] cpu_addr_i,
    input wire logic        ram_range_hit_i,
    input wire logic [31:0] paddr,
    input wire logic        psel,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [1:0]  op_mode_o,
    input wire logic        rom_enable_o,
    input wire logic        expanded_o,
    input wire logic        bus16_o,
    input wire logic [23:0] ext_addr_o,
    input wire logic [1:0]  irq_ctrl_mode_o,
    input wire logic        nonmask_irq_edge_sel_o,
    input wire logic        low_byte_write_strobe_en_o,
    input wire logic        onchip_ram_enable_o,
    input wire logic        ram_to_external_o,
    input wire logic        flash_regs_select_o,
    input wire logic        flash_window_hit_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Completed write to the system control register
    sequence s_wctl;
        pready && psel && pwrite && paddr[15:0] == `MSC_ADDR_SYSCTL;
    endsequence
    property p_modrd;
        pready && psel && !pwrite && paddr[15:0] == `MSC_ADDR_MODE
            |-> prdata == {24'h00_0000, `MSC_MODE_FIXED | {5'h00, mode_pins_i}};
    endproperty
    a_modrd: assert property (p_modrd)
        else $error("mode readback wrong");
    property p_ctl;
        s_wctl |-> ##2 {irq_ctrl_mode_o, nonmask_irq_edge_sel_o,
            onchip_ram_enable_o} == {$past(pwdata[5:3], 2), $past(pwdata[0], 2)};
    endproperty
    a_ctl: assert property (p_ctl)
        else $error("control fields wrong");
    property p_strb;
        s_wctl |-> ##3 low_byte_write_strobe_en_o
            == (!$past(pwdata[2], 3) && expanded_o);
    endproperty
    a_strb: assert property (p_strb)
        else $error("strobe enable wrong");
    property p_stby;
        hw_standby_i [*2] |=> !flash_regs_select_o;
    endproperty
    a_stby: assert property (p_stby)
        else $error("gate not cleared");
    property p_win;
        flash_window_hit_o == (flash_regs_select_o
            && ext_addr_o >= `MSC_FLASH_LO && ext_addr_o <= `MSC_FLASH_HI);
    endproperty
    a_win: assert property (p_win)
        else $error("flash window wrong");
    property p_r2e;
        $past(rst_n_i) |-> ram_to_external_o
            == ($past(ram_range_hit_i) && !onchip_ram_enable_o);
    endproperty
    a_r2e: assert property (p_r2e)
        else $error("ram redirect wrong");
    property p_addr;
        $past(rst_n_i) |-> ext_addr_o == $past(cpu_addr_i[23:0]);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address not 24 bits");
    property p_bus;
        $stable(expanded_o) ##1 $stable(expanded_o)
            |-> bus16_o == (expanded_o && $past(area_is16_i) != 8'h00);
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus width wrong");
    property p_dec;
        $past(rst_n_i) && $past(rst_n_i, 2) && mode_pins_i[2]
            |-> op_mode_o == mode_pins_i[1:0] && rom_enable_o == mode_pins_i[1]
            && expanded_o == (mode_pins_i != 3'h7);
    endproperty
    a_dec: assert property (p_dec)
        else $error("mode decode wrong");
endmodule : msc_sva

bind msc_top msc_sva u_sva (.mclk_i, .rst_n_i, .mode_pins_i, .hw_standby_i,
    .area_is16_i, .cpu_addr_i, .ram_range_hit_i, .paddr, .psel, .pwrite,
    .pwdata, .prdata, .pready, .op_mode_o, .rom_enable_o, .expanded_o,
    .bus16_o, .ext_addr_o, .irq_ctrl_mode_o, .nonmask_irq_edge_sel_o,
    .low_byte_write_strobe_en_o, .onchip_ram_enable_o, .ram_to_external_o,
    .flash_regs_select_o, .flash_window_hit_o);

// ===== msc_top.sv
// Mode selection and system control registers behind an APB slave
`timescale 1ns/1ps
`include "msc_regs.svh"
// Summary of operation
// - Pins 100/101/110/111 select modes 4..7
// - Initial bus width set by the areas alone, same in mode 4 and mode 5
// - Any 16-bit area forces 16-bit bus in modes 4..6
// - CPU addresses limited to 16 Mbytes
// - Mode bit 7 reads 1, bits 6..3 zero
// - Mode bits 2..0 latch pins on read
// - Control bits 5..4 select interrupt mode
// - Control bit 3 selects NMI edge
// - Control bit 2 disables low write strobe
// - Control bit 0 enables on-chip RAM
// - Reset values H'01 and H'00
// - Flash gate bit 3 maps flash registers
// - Without flash, gate reads undefined, ignores writes
// - Decode lower 16 address bits only
// - RAM disabled sends accesses external
module msc_top
#(
    parameter bit HAS_FLASH = 1'b1
)
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  mode_pins_i,
    input  wire logic        hw_standby_i,
    input  wire logic [7:0]  area_is16_i,
    input  wire logic [31:0] cpu_addr_i,
    input  wire logic        ram_range_hit_i,
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [1:0]       op_mode_o,
    output logic             rom_enable_o,
    output logic             expanded_o,
    output logic             bus16_o,
    output logic [23:0]      ext_addr_o,
    output logic [1:0]       irq_ctrl_mode_o,
    output logic             irq_mode_prohibited_o,
    output logic             nonmask_irq_edge_sel_o,
    output logic             low_byte_write_strobe_en_o,
    output logic             onchip_ram_enable_o,
    output logic             ram_to_external_o,
    output logic             flash_regs_select_o,
    output logic             flash_window_hit_o
);
    logic [7:0]  system_control;
    logic [7:0]  flash_reg_gate;
    logic [7:0]  next_system_control;
    logic [7:0]  next_flash_reg_gate;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [2:0]  pin_readback;
    logic [2:0]  strap;
    logic        strap_valid;
    logic        rd_mode;
    logic        acc;
    logic        hit_ctl;
    logic        hit_mode;
    logic        hit_gate;
    msc_pkg::msc_mode_t next_mode;
    logic        next_bus16;
    logic        next_rom;
    logic        next_exp;

    // Only lower 16 address bits compared
    function automatic logic addr_hit(input logic [31:0] a,
                                      input logic [15:0] off);
        addr_hit = (a[15:0] == off);
    endfunction : addr_hit

    assign acc      = psel && penable && !pready;
    assign hit_ctl  = addr_hit(paddr, `MSC_ADDR_SYSCTL);
    assign hit_mode = addr_hit(paddr, `MSC_ADDR_MODE);
    assign hit_gate = addr_hit(paddr, `MSC_ADDR_FGATE);
    assign rd_mode  = acc && !pwrite && hit_mode;

    msc_mode_latch u_latch
    (
        .mclk_i        (mclk_i),
        .rst_n_i       (rst_n_i),
        .mode_pins_i   (mode_pins_i),
        .rd_mode_i     (rd_mode),
        .readback_o    (pin_readback),
        .strap_o       (strap),
        .strap_valid_o (strap_valid)
    );

    // Register file and APB answer, one wait state
    always_comb
    begin
        next_system_control = system_control;
        next_flash_reg_gate = flash_reg_gate;
        next_prdata         = prdata;
        next_pready         = 1'b0;
        next_pslverr        = 1'b0;
        if (hw_standby_i)
        begin
            next_flash_reg_gate = `MSC_FGATE_RESET;
        end
        if (acc)
        begin
            next_pready = 1'b1;
            next_prdata = `MSC_ZERO32;
            if (hit_ctl)
            begin
                if (pwrite)
                begin
                    // Bit 6 fixed zero; bits 7 and 1 kept at zero
                    next_system_control = pwdata[7:0] & `MSC_SYSCTL_WMASK;
                end
                else
                begin
                    next_prdata[7:0] = system_control;
                end
            end
            else if (hit_mode)
            begin
                if (!pwrite)
                begin
                    // Pins latched by this read
                    next_prdata[7:0] = `MSC_MODE_FIXED
                                       | {5'h00, mode_pins_i};
                end
            end
            else if (hit_gate)
            begin
                if (!HAS_FLASH)
                begin
                    next_prdata[7:0] = `MSC_UNDEF_VALUE;
                end
                else if (pwrite && !hw_standby_i)
                begin
                    next_flash_reg_gate = pwdata[7:0]
                                          & `MSC_FGATE_WMASK;
                end
                else if (!pwrite)
                begin
                    next_prdata[7:0] = flash_reg_gate;
                end
            end
            else
            begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            system_control <= `MSC_SYSCTL_RESET;
            flash_reg_gate <= `MSC_FGATE_RESET;
            prdata         <= `MSC_ZERO32;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
        end
        else
        begin
            system_control <= next_system_control;
            flash_reg_gate <= next_flash_reg_gate;
            prdata         <= next_prdata;
            pready         <= next_pready;
            pslverr        <= next_pslverr;
        end
    end

    // Mode decode from the reset-time strap
    always_comb
    begin
        next_mode  = msc_pkg::MSC_MODE_SINGLE;
        next_rom   = 1'b1;
        next_exp   = 1'b0;
        next_bus16 = 1'b0;
        case (strap)
            `MSC_PINS_MODE4:
            begin
                next_mode = msc_pkg::MSC_MODE_EXP_NOROM_16;
                next_rom  = 1'b0;
                next_exp  = 1'b1;
            end
            `MSC_PINS_MODE5:
            begin
                next_mode = msc_pkg::MSC_MODE_EXP_NOROM_8;
                next_rom  = 1'b0;
                next_exp  = 1'b1;
            end
            `MSC_PINS_MODE6:
            begin
                next_mode = msc_pkg::MSC_MODE_EXP_ROM;
                next_exp  = 1'b1;
            end
            default:
            begin
                next_mode = msc_pkg::MSC_MODE_SINGLE;
            end
        endcase
        // Bus is 16 bits in expanded modes when any area is 16-bit
        if (next_exp)
        begin
            next_bus16 = (|area_is16_i);
        end
        if (!strap_valid)
        begin
            next_exp   = 1'b0;
            next_bus16 = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            op_mode_o                  <= msc_pkg::MSC_MODE_SINGLE;
            rom_enable_o               <= 1'b0;
            expanded_o                 <= 1'b0;
            bus16_o                    <= 1'b0;
            ext_addr_o                 <= 24'h00_0000;
            irq_ctrl_mode_o            <= 2'h0;
            irq_mode_prohibited_o      <= 1'b0;
            nonmask_irq_edge_sel_o     <= 1'b0;
            low_byte_write_strobe_en_o <= 1'b1;
            onchip_ram_enable_o        <= 1'b1;
            ram_to_external_o          <= 1'b0;
            flash_regs_select_o        <= 1'b0;
            flash_window_hit_o         <= 1'b0;
        end
        else
        begin
            op_mode_o    <= next_mode;
            rom_enable_o <= next_rom;
            expanded_o   <= next_exp;
            bus16_o      <= next_bus16;
            ext_addr_o   <= cpu_addr_i[`MSC_ADDR_LIMIT_BITS-1:0];
            irq_ctrl_mode_o <= {system_control[`MSC_BIT_INTM_HI],
                                system_control[`MSC_BIT_INTM_LO]};
            irq_mode_prohibited_o <= system_control[`MSC_BIT_INTM_LO];
            nonmask_irq_edge_sel_o <= system_control[`MSC_BIT_NONMASK_IRQ_EDGE_SEL];
            low_byte_write_strobe_en_o <=
                !system_control[`MSC_BIT_LOW_STROBE_OUT_DISABLE] && expanded_o;
            onchip_ram_enable_o <= system_control[`MSC_BIT_ONCHIP_RAM_ENABLE];
            ram_to_external_o <= ram_range_hit_i
                && !system_control[`MSC_BIT_ONCHIP_RAM_ENABLE];
            flash_regs_select_o <= flash_reg_gate[`MSC_BIT_FLASH_REGS_SELECT];
            flash_window_hit_o <= flash_reg_gate[`MSC_BIT_FLASH_REGS_SELECT]
                && (cpu_addr_i[23:0] >= `MSC_FLASH_LO)
                && (cpu_addr_i[23:0] <= `MSC_FLASH_HI);
        end
    end
endmodule : msc_top

// ===== tb.sv
// Self-checking testbench for the mode and system control block
`timescale 1ns/1ps
module tb;
    logic        mclk_i = 1'b0, rst_n_i = 1'b0, hw_standby_i = 1'b0;
    logic        ram_range_hit_i = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, serr;
    logic [2:0]  mode_pins_i = 3'h4;
    logic [7:0]  area_is16_i = 8'hFF;
    logic [31:0] cpu_addr_i = '0, paddr = '0, pwdata = '0, rd;
    wire  [31:0] prdata;
    wire  [23:0] ext_addr_o;
    wire  [1:0]  op_mode_o, irq_ctrl_mode_o;
    wire         pready, pslverr, rom_enable_o, expanded_o, bus16_o;
    wire         irq_mode_prohibited_o, nonmask_irq_edge_sel_o;
    wire         low_byte_write_strobe_en_o, onchip_ram_enable_o;
    wire         ram_to_external_o, flash_regs_select_o, flash_window_hit_o;
    int          num_errors = 0, check_count = 0;

    msc_top u_dut (.mclk_i, .rst_n_i, .mode_pins_i, .hw_standby_i,
        .area_is16_i, .cpu_addr_i, .ram_range_hit_i, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .op_mode_o, .rom_enable_o,
        .expanded_o, .bus16_o, .ext_addr_o, .irq_ctrl_mode_o,
        .irq_mode_prohibited_o, .nonmask_irq_edge_sel_o,
        .low_byte_write_strobe_en_o, .onchip_ram_enable_o, .ram_to_external_o,
        .flash_regs_select_o, .flash_window_hit_o);

    always #4 mclk_i = ~mclk_i;

    task check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge mclk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        // Wait until pready is seen high; the watchdog ends a hung wait
        do
        begin
            @(posedge mclk_i);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_modes();
        // Legal straps only, changed only while in reset
        for (int m = 7; m >= 4; m--)
        begin
            rst_n_i     <= 1'b0;
            mode_pins_i <= m[2:0];
            area_is16_i <= 8'h00;
            repeat (12) @(posedge mclk_i);
            rst_n_i <= 1'b1;
            repeat (4) @(posedge mclk_i);
            check("op_mode", op_mode_o, m - 4);
            check("rom_en", rom_enable_o, m >= 6);
            check("expanded", expanded_o, m != 7);
            check("bus_all8", bus16_o, 1'b0);
            area_is16_i <= 8'h40;
            repeat (3) @(posedge mclk_i);
            check("bus_one16", bus16_o, m != 7);
            apb(1'b1, 32'h00C0_FF3B, 32'h0000_00FF);
            apb(1'b0, 32'h00C0_FF3B, '0);
            check("mode_rd", rd, 32'h80 | m);
        end
    endtask : t_modes

    task automatic t_sysctl();
        logic [7:0] v [4] = '{8'hFF, 8'h20, 8'h10, 8'h00};
        apb(1'b0, 32'h0000_FF39, '0);
        check("ctl_reset", rd, 32'h01);
        apb(1'b0, 32'h0000_FF42, '0);
        check("gate_reset", rd, 32'h00);
        ram_range_hit_i <= 1'b1;
        foreach (v[i])
        begin
            apb(1'b1, 32'h0000_FF39, {24'h00_0000, v[i]});
            repeat (4) @(posedge mclk_i);
            check("irq_mode", irq_ctrl_mode_o, v[i][5:4]);
            check("irq_bad", irq_mode_prohibited_o, v[i][4]);
            check("edge_sel", nonmask_irq_edge_sel_o, v[i][3]);
            check("strobe_en", low_byte_write_strobe_en_o,
                  !v[i][2]);
            check("ram_en", onchip_ram_enable_o, v[i][0]);
            check("ram_ext", ram_to_external_o, !v[i][0]);
            apb(1'b0, 32'h0000_FF39, '0);
            check("ctl_rd", rd, v[i] & 8'h3D);
        end
    endtask : t_sysctl

    task automatic t_gate();
        cpu_addr_i <= 32'h12FF_FFC8;
        apb(1'b1, 32'h0000_FF42, 32'h0000_00FF);
        apb(1'b0, 32'h0000_FF42, '0);
        check("gate_rd", rd, 32'h08);
        check("window_in", flash_window_hit_o, 1'b1);
        check("ext_addr", ext_addr_o, 24'hFF_FFC8);
        cpu_addr_i <= 32'h00FF_FFCC;
        repeat (2) @(posedge mclk_i);
        check("window_out", flash_window_hit_o, 1'b0);
        hw_standby_i <= 1'b1;
        apb(1'b1, 32'h0000_FF42, 32'h0000_0008);
        hw_standby_i <= 1'b0;
        apb(1'b0, 32'h0000_FF42, '0);
        check("gate_stby", rd, 32'h00);
        apb(1'b1, 32'h0000_FF40, '0);
        check("unmapped", serr, 1'b1);
    endtask : t_gate

    task test_done();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    initial
    begin
        t_modes();
        t_sysctl();
        t_gate();
        test_done();
    end

    // Hang guard
    initial
    begin
        repeat (5000) @(posedge mclk_i);
        num_errors++;
        test_done();
    end
endmodule : tb
